// ===== mode_ctl_map.svh
`ifndef MODE_CTL_MAP_SVH
`define MODE_CTL_MAP_SVH
// register offsets
`define OFS_CORE_FLAGS        8'h0f
`define OFS_CORE_MODE_CONTROL 8'h20
`define OFS_TIMER_ONE_CONTROL 8'h2a
`define OFS_PORT_A_WAKE       8'h34
`define OFS_RESERVED_FIXED    8'h2f
// field positions
`define BIT_CLOCK_SPEED_SELECT 0
`define BIT_STANDBY_DEPTH      1
`define BIT_GLOBAL_INT         2
`define BIT_BANK_SELECT        7
`define BIT_POWERDOWN_FLAG     6
`define BIT_TIMEOUT_FLAG       7
`define BIT_TIMER_ONE_WAKE     7
// implemented-bit masks and the software-writable flag mask
`define MASK_CORE_MODE   8'h87
`define MASK_TIMER_ONE   8'h9b
`define MASK_CORE_FLAGS  8'hff
`define MASK_FLAGS_SW    8'h3f
// reset values
`define RST_TIMER_ONE    8'h00
`define RST_PORT_A_WAKE  8'h00
`define RST_BYTE_ZERO    8'h00
`define RST_CORE_FLAGS   8'hc0
// timing
`define FAST_SWITCH_COUNT 6'd32
`define FAST_SWITCH_DELAY_NS 100000
`define CLK_PERIOD_NS 8
`endif

// ===== mode_ctl_pkg.sv
package mode_ctl_pkg;
   typedef enum logic [2:0] {
      ST_SLOW     = 3'b000,
      ST_SWITCH   = 3'b001,
      ST_FAST     = 3'b010,
      ST_STANDBY  = 3'b011,
      ST_HALT     = 3'b100,
      ST_WARM     = 3'b101
   } op_state_e;

   typedef struct packed {
      op_state_e   state;
      logic [7:0]  mode_ctl;
      logic [7:0]  flags;
      logic [7:0]  timer_ctl;
      logic [7:0]  wake_en;
      logic [5:0]  fast_cnt;
      logic [15:0] delay_cnt;
      logic [15:0] warm_cnt;
      logic [7:0]  rdata;
      logic        use_fast;
      logic        fast_osc_on;
      logic        slow_osc_on;
      logic        core_run;
      logic        timers_run;
      logic        int_hold;
      logic        strap_pending;
   } ctl_state_s;
endpackage

// ===== operating_mode_wake_control.sv
`timescale 1ns/1ps
`include "mode_ctl_map.svh"
module operating_mode_wake_control
   import mode_ctl_pkg::*;
#(
   parameter int WARM_CYCLES = 16'd1000,   // oscillator settle time after deep halt
   parameter int OPTION_WAKE_EDGE = 0      // reserved for future wake polarity
)(
   input  wire logic       clk_sys_in,             // 125 MHz system clock
   input  wire logic       reset_in,               // synchronous reset, active high
   input  wire logic       por_event_in,           // power-on reset pulse
   input  wire logic       reset_pin_low_active_in,// reset pin level, low active
   input  wire logic       watchdog_timeout_in,    // watchdog timeout reset pulse
   input  wire logic       initial_mode_option_in, // nonvolatile initial mode
   input  wire logic       halt_instruction_in,    // halt instruction executed
   input  wire logic       watchdog_clear_instruction_in, // clear instruction pulse
   input  wire logic [7:0] port_a_in,              // port A pins, async
   input  wire logic       timer_one_underflow_in, // timer one underflow pulse
   input  wire logic       fast_oscillator_clock_in, // fast osc tick, async
   input  wire logic [7:0] addr_in,                // register address
   input  wire logic [7:0] wdata_in,               // register write data
   input  wire logic       wr_in,                  // write strobe
   input  wire logic       rd_in,                  // read strobe
   output logic      [7:0] rdata_out,              // read data, cycle after rd
   output logic            use_fast_clock_out,     // system clock source fast
   output logic            fast_osc_enable_out,    // fast oscillator on
   output logic            slow_osc_enable_out,    // slow oscillator on
   output logic            core_run_out,           // core clock running
   output logic            timers_run_out,         // timers may count
   output logic            int_hold_out,           // interrupts recorded not served
   output logic      [7:0] core_mode_control_out,  // mode register copy
   output logic      [7:0] core_flags_out          // status register copy
);
   localparam int DELAY_CYCLES = (`FAST_SWITCH_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   // refuse settings the warm-up and delay counters, their checks and the pin wake logic cannot serve
   if (WARM_CYCLES < 2 || WARM_CYCLES > 65535) begin : g_bad_warm
      $error("WARM_CYCLES out of range");
   end
   if (DELAY_CYCLES > 65535) begin : g_bad_delay
      $error("switch delay too long");
   end
   if (OPTION_WAKE_EDGE != 0) begin : g_bad_edge
      $error("only low-level pin wake is built");
   end

   // two-flop synchronisers for pins and the fast oscillator tick
   logic [7:0] pa_s1_reg, pa_s2_reg;
   logic       fo_s1_reg, fo_s2_reg, fo_s3_reg;
   logic       rp_s1_reg, rp_s2_reg;
   always_ff @(posedge clk_sys_in) begin
      pa_s1_reg <= port_a_in;
      pa_s2_reg <= pa_s1_reg;
      fo_s1_reg <= fast_oscillator_clock_in;
      fo_s2_reg <= fo_s1_reg;
      fo_s3_reg <= fo_s2_reg;
      rp_s1_reg <= reset_pin_low_active_in;
      rp_s2_reg <= rp_s1_reg;
   end

   ctl_state_s s_reg, s_next;
   logic       fast_tick;
   logic       pin_wake;
   logic       tmr_wake;
   logic       hard_reset;
   logic       low_power;

   assign fast_tick  = fo_s2_reg & ~fo_s3_reg;
   assign hard_reset = por_event_in | ~rp_s2_reg;
   assign low_power  = (s_reg.state == ST_STANDBY) || (s_reg.state == ST_HALT);

   // pin wake is a low level on an enabled pin; one gate per pin
   logic [7:0] pin_hit;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_wake
         assign pin_hit[gi] = s_reg.wake_en[gi] & ~pa_s2_reg[gi];
      end
   endgenerate
   assign pin_wake = |pin_hit;
   assign tmr_wake = s_reg.timer_ctl[`BIT_TIMER_ONE_WAKE] & timer_one_underflow_in;

   // next-state logic; registers only change on bus writes or flag events
   always_comb begin
      s_next = s_reg;
      s_next.rdata = `RST_BYTE_ZERO;
      if (rd_in) begin
         case (addr_in)
            `OFS_CORE_FLAGS:        s_next.rdata = s_reg.flags & `MASK_CORE_FLAGS;
            `OFS_CORE_MODE_CONTROL: s_next.rdata = s_reg.mode_ctl & `MASK_CORE_MODE;
            `OFS_TIMER_ONE_CONTROL: s_next.rdata = s_reg.timer_ctl & `MASK_TIMER_ONE;
            `OFS_PORT_A_WAKE:       s_next.rdata = s_reg.wake_en;
            default:                s_next.rdata = `RST_BYTE_ZERO;
         endcase
      end
      // writes are only possible while the core runs; halt keeps everything
      if (wr_in && s_reg.core_run) begin
         case (addr_in)
            `OFS_CORE_FLAGS: begin
               // timeout and power-down bits are hardware-owned
               s_next.flags = (s_reg.flags & ~`MASK_FLAGS_SW) | (wdata_in & `MASK_FLAGS_SW);
            end
            `OFS_CORE_MODE_CONTROL: s_next.mode_ctl = wdata_in & `MASK_CORE_MODE;
            `OFS_TIMER_ONE_CONTROL: s_next.timer_ctl = wdata_in & `MASK_TIMER_ONE;
            `OFS_PORT_A_WAKE:       s_next.wake_en = wdata_in;
            default: ;
         endcase
      end
      if (watchdog_clear_instruction_in) begin
         s_next.flags[`BIT_POWERDOWN_FLAG] = 1'b1;
         s_next.flags[`BIT_TIMEOUT_FLAG]   = 1'b1;
      end

      case (s_reg.state)
         ST_SLOW: begin
            s_next.use_fast = 1'b0;
            if (halt_instruction_in) begin
               if (s_reg.mode_ctl[`BIT_STANDBY_DEPTH]) begin
                  s_next.state = ST_STANDBY;
               end else begin
                  s_next.state = ST_HALT;
                  s_next.flags[`BIT_POWERDOWN_FLAG] = 1'b0;
                  s_next.flags[`BIT_TIMEOUT_FLAG]   = 1'b1;
               end
            end else if (s_next.mode_ctl[`BIT_CLOCK_SPEED_SELECT]) begin
               s_next.state     = ST_SWITCH;
               s_next.fast_cnt  = '0;
               s_next.delay_cnt = '0;
            end
         end
         ST_SWITCH: begin
            s_next.fast_osc_on = 1'b1;
            if (!s_reg.mode_ctl[`BIT_CLOCK_SPEED_SELECT]) begin
               s_next.state = ST_SLOW;
            end else begin
               if (fast_tick && s_reg.fast_cnt != `FAST_SWITCH_COUNT)
                  s_next.fast_cnt = s_reg.fast_cnt + 6'd1;
               if (s_reg.delay_cnt != 16'(DELAY_CYCLES))
                  s_next.delay_cnt = s_reg.delay_cnt + 16'd1;
               if (s_reg.fast_cnt == `FAST_SWITCH_COUNT && s_reg.delay_cnt == 16'(DELAY_CYCLES)) begin
                  s_next.state    = ST_FAST;
                  s_next.use_fast = 1'b1;
               end
            end
         end
         ST_FAST: begin
            s_next.use_fast = 1'b1;
            if (halt_instruction_in) begin
               if (s_reg.mode_ctl[`BIT_STANDBY_DEPTH]) begin
                  s_next.state = ST_STANDBY;
               end else begin
                  s_next.state = ST_HALT;
                  s_next.flags[`BIT_POWERDOWN_FLAG] = 1'b0;
                  s_next.flags[`BIT_TIMEOUT_FLAG]   = 1'b1;
               end
            end else if (!s_next.mode_ctl[`BIT_CLOCK_SPEED_SELECT]) begin
               s_next.state    = ST_SLOW;
               s_next.use_fast = 1'b0;
            end
         end
         ST_STANDBY: begin
            // slow oscillator stays up so timer one can still wake us
            if (pin_wake || tmr_wake) begin
               s_next.state = s_reg.mode_ctl[`BIT_CLOCK_SPEED_SELECT] ? ST_FAST : ST_SLOW;
            end
         end
         ST_HALT: begin
            if (pin_wake) begin
               s_next.state    = ST_WARM;
               s_next.warm_cnt = '0;
            end
         end
         ST_WARM: begin
            // hold core until the restarted oscillator settles
            s_next.warm_cnt = s_reg.warm_cnt + 16'd1;
            if (s_reg.warm_cnt == 16'(WARM_CYCLES - 1)) begin
               s_next.state = s_reg.mode_ctl[`BIT_CLOCK_SPEED_SELECT] ? ST_FAST : ST_SLOW;
            end
         end
         default: s_next.state = ST_SLOW;
      endcase

      // derived oscillator and core enables from the next state
      s_next.core_run    = (s_next.state == ST_SLOW) || (s_next.state == ST_SWITCH) ||
                           (s_next.state == ST_FAST);
      s_next.timers_run  = s_next.core_run;
      s_next.int_hold    = ~s_next.core_run;
      s_next.slow_osc_on = (s_next.state != ST_HALT);
      s_next.fast_osc_on = (s_next.state == ST_SWITCH) || (s_next.state == ST_FAST) ||
                           (s_next.state == ST_WARM && s_reg.mode_ctl[`BIT_CLOCK_SPEED_SELECT]);
      s_next.use_fast    = (s_next.state == ST_FAST);
      s_next.strap_pending = 1'b0;
   end

   // one register for all state; reset_in takes constants, option caught after; other resets load the option at once
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         s_reg <= '0;
         s_reg.state         <= ST_SLOW;
         s_reg.timer_ctl     <= `RST_TIMER_ONE;
         s_reg.wake_en       <= `RST_PORT_A_WAKE;
         s_reg.flags         <= `RST_CORE_FLAGS;
         s_reg.core_run      <= 1'b1;
         s_reg.timers_run    <= 1'b1;
         s_reg.slow_osc_on   <= 1'b1;
         s_reg.strap_pending <= 1'b1;
      end else if (hard_reset || watchdog_timeout_in) begin
         s_reg <= s_reg;
         s_reg.state      <= ST_SLOW;
         s_reg.mode_ctl   <= {7'd0, initial_mode_option_in};
         s_reg.timer_ctl  <= `RST_TIMER_ONE;
         s_reg.wake_en    <= `RST_PORT_A_WAKE;
         s_reg.core_run   <= 1'b1;
         s_reg.timers_run <= 1'b1;
         s_reg.int_hold   <= 1'b0;
         s_reg.use_fast   <= 1'b0;
         s_reg.slow_osc_on <= 1'b1;
         s_reg.fast_osc_on <= 1'b0;
         s_reg.rdata      <= `RST_BYTE_ZERO;
         if (hard_reset) begin
            s_reg.flags[`BIT_TIMEOUT_FLAG]   <= 1'b1;
            s_reg.flags[`BIT_POWERDOWN_FLAG] <= 1'b1;
         end else begin
            s_reg.flags[`BIT_TIMEOUT_FLAG]   <= 1'b0;
         end
      end else if (s_reg.strap_pending) begin
         s_reg <= s_reg;
         s_reg.mode_ctl[`BIT_CLOCK_SPEED_SELECT] <= initial_mode_option_in;
         s_reg.strap_pending <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state register
   assign rdata_out             = s_reg.rdata;
   assign use_fast_clock_out    = s_reg.use_fast;
   assign fast_osc_enable_out   = s_reg.fast_osc_on;
   assign slow_osc_enable_out   = s_reg.slow_osc_on;
   assign core_run_out          = s_reg.core_run;
   assign timers_run_out        = s_reg.timers_run;
   assign int_hold_out          = s_reg.int_hold;
   assign core_mode_control_out = s_reg.mode_ctl;
   assign core_flags_out        = s_reg.flags;

   // assertions
   sequence s_halt_entry;
      (s_reg.state == ST_SLOW || s_reg.state == ST_FAST) && halt_instruction_in &&
      !s_reg.mode_ctl[`BIT_STANDBY_DEPTH] && !hard_reset && !watchdog_timeout_in && !s_reg.strap_pending;
   endsequence

   property p_halt_clears_pd;
      @(posedge clk_sys_in) disable iff (reset_in)
      s_halt_entry ##1 !hard_reset |-> !core_flags_out[`BIT_POWERDOWN_FLAG] || watchdog_clear_instruction_in;
   endproperty
   a_halt_clears_pd: assert property (p_halt_clears_pd) else $error("halt did not clear power-down");

   property p_halt_osc_off;
      @(posedge clk_sys_in) disable iff (reset_in)
      (s_reg.state == ST_HALT) |-> !slow_osc_enable_out && !fast_osc_enable_out && !core_run_out;
   endproperty
   a_halt_osc_off: assert property (p_halt_osc_off) else $error("oscillator running in deep halt");

   property p_halt_holds_regs;
      @(posedge clk_sys_in) disable iff (reset_in || hard_reset || watchdog_timeout_in)
      (s_reg.state == ST_HALT) ##1 (s_reg.state == ST_HALT) |-> $stable(core_mode_control_out) && $stable(s_reg.wake_en);
   endproperty
   a_halt_holds_regs: assert property (p_halt_holds_regs) else $error("register changed in deep halt");

   property p_standby_slow_on;
      @(posedge clk_sys_in) disable iff (reset_in)
      (s_reg.state == ST_STANDBY) |-> slow_osc_enable_out && !core_run_out && int_hold_out && !timers_run_out;
   endproperty
   a_standby_slow_on: assert property (p_standby_slow_on) else $error("standby enables wrong");

   property p_fast_needs_count;
      @(posedge clk_sys_in) disable iff (reset_in)
      $rose(use_fast_clock_out) && $past(s_reg.state) == ST_SWITCH |->
         $past(s_reg.fast_cnt) == `FAST_SWITCH_COUNT;
   endproperty
   a_fast_needs_count: assert property (p_fast_needs_count) else $error("fast switch before count");

   property p_wd_clears_to;
      @(posedge clk_sys_in) disable iff (reset_in)
      watchdog_timeout_in && !hard_reset && !s_reg.strap_pending |=> !core_flags_out[`BIT_TIMEOUT_FLAG];
   endproperty
   a_wd_clears_to: assert property (p_wd_clears_to) else $error("watchdog did not clear timeout");

   property p_hard_sets_both;
      @(posedge clk_sys_in) disable iff (reset_in)
      hard_reset && !s_reg.strap_pending |=> core_flags_out[`BIT_TIMEOUT_FLAG] &&
         core_flags_out[`BIT_POWERDOWN_FLAG] && !use_fast_clock_out;
   endproperty
   a_hard_sets_both: assert property (p_hard_sets_both) else $error("reset did not set flags");

   property p_read_zero_bits;
      @(posedge clk_sys_in) disable iff (reset_in)
      rd_in && addr_in == `OFS_CORE_MODE_CONTROL |=> (rdata_out & ~`MASK_CORE_MODE) == `RST_BYTE_ZERO;
   endproperty
   a_read_zero_bits: assert property (p_read_zero_bits) else $error("unimplemented bits not zero");

   property p_warm_holds_core;
      @(posedge clk_sys_in) disable iff (reset_in || hard_reset || watchdog_timeout_in)
      (s_reg.state == ST_HALT) ##1 (s_reg.state == ST_WARM) |-> !core_run_out [*2];
   endproperty
   a_warm_holds_core: assert property (p_warm_holds_core) else $error("core ran before warm-up");

   property p_fast_needs_delay;
      @(posedge clk_sys_in) disable iff (reset_in)
      $rose(use_fast_clock_out) && $past(s_reg.state) == ST_SWITCH |->
         $past(s_reg.delay_cnt) == 16'(DELAY_CYCLES);
   endproperty
   a_fast_needs_delay: assert property (p_fast_needs_delay) else $error("fast switch before delay");

   sequence s_standby_entry;
      (s_reg.state == ST_SLOW || s_reg.state == ST_FAST) && halt_instruction_in &&
      s_reg.mode_ctl[`BIT_STANDBY_DEPTH] && !hard_reset && !watchdog_timeout_in && !s_reg.strap_pending;
   endsequence

   property p_standby_entry;
      @(posedge clk_sys_in) disable iff (reset_in)
      s_standby_entry |=> s_reg.state == ST_STANDBY && slow_osc_enable_out;
   endproperty
   a_standby_entry: assert property (p_standby_entry) else $error("standby not entered");

   sequence s_standby_quiet;
      s_reg.state == ST_STANDBY && !pin_wake && !hard_reset && !watchdog_timeout_in;
   endsequence

   property p_timer_wake_gated;
      @(posedge clk_sys_in) disable iff (reset_in)
      s_standby_quiet ##0 !s_reg.timer_ctl[`BIT_TIMER_ONE_WAKE] |=> s_reg.state == ST_STANDBY;
   endproperty
   a_timer_wake_gated: assert property (p_timer_wake_gated) else $error("disabled timer woke standby");

   // judged from the synchronised pins, not from the wake gates themselves
   property p_halt_pin_gated;
      @(posedge clk_sys_in) disable iff (reset_in)
      s_reg.state == ST_HALT && (s_reg.wake_en & ~pa_s2_reg) == `RST_BYTE_ZERO && !hard_reset &&
         !watchdog_timeout_in |=> s_reg.state == ST_HALT;
   endproperty
   a_halt_pin_gated: assert property (p_halt_pin_gated) else $error("masked pin woke deep halt");

   property p_warm_length;
      @(posedge clk_sys_in) disable iff (reset_in)
      s_reg.state == ST_WARM && s_reg.warm_cnt != 16'(WARM_CYCLES - 1) && !hard_reset &&
         !watchdog_timeout_in |=> s_reg.state == ST_WARM;
   endproperty
   a_warm_length: assert property (p_warm_length) else $error("warm-up cut short");

   property p_strap_loads_option;
      @(posedge clk_sys_in) disable iff (reset_in)
      s_reg.strap_pending && !reset_in |=>
         core_mode_control_out[`BIT_CLOCK_SPEED_SELECT] == $past(initial_mode_option_in);
   endproperty
   a_strap_loads_option: assert property (p_strap_loads_option) else $error("speed select not from option");

   property p_low_power_hold;
      @(posedge clk_sys_in) disable iff (reset_in)
      low_power |-> !timers_run_out && int_hold_out;
   endproperty
   a_low_power_hold: assert property (p_low_power_hold) else $error("timers live in low power");
endmodule

// ===== core_model.sv
`timescale 1ns/1ps
`include "mode_ctl_map.svh"
// stand-in for the processor core: register accesses and mode instructions
module core_model (
   input  wire logic       clk_sys_in, // system clock
   output logic      [7:0] addr_out,   // register address
   output logic      [7:0] wdata_out,  // register write data
   output logic            wr_out,     // write strobe
   output logic            rd_out,     // read strobe
   output logic            halt_out,   // halt instruction pulse
   output logic            wdclr_out   // watchdog clear instruction pulse
);
   // bus idle at time zero
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
      halt_out = 1'b0;
      wdclr_out = 1'b0;
   end

   // one-cycle access; address and data are scrambled afterwards so stale values never look valid
   task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
      @(posedge clk_sys_in);
      addr_out <= a;
      wdata_out <= (a == `OFS_RESERVED_FIXED) ? 8'h00 : d;
      wr_out <= w;
      rd_out <= ~w;
      @(posedge clk_sys_in);
      wr_out <= 1'b0;
      rd_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask

   // one-cycle instruction pulse: halt when clr is 0, watchdog clear when 1
   task automatic instr(input logic clr);
      @(posedge clk_sys_in);
      halt_out <= ~clr;
      wdclr_out <= clr;
      @(posedge clk_sys_in);
      halt_out <= 1'b0;
      wdclr_out <= 1'b0;
   endtask
endmodule

// ===== operating_mode_wake_control_test.sv
`timescale 1ns/1ps
`include "mode_ctl_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
`define WAITC(c, n) begin wcnt = 0; while (!(c) && wcnt < (n)) begin tick(1); wcnt++; end \
   if (!(c)) begin num_errors++; $display("ERROR wait_bound expected 1 seen 0"); test_done(); end end
module operating_mode_wake_control_test;
   localparam int WARM = 4;
   logic       clk_sys_in = 1'b0;
   logic       reset_in = 1'b1;
   logic       fosc = 1'b0;
   logic       opt = 1'b0;
   logic [4:0] ev = 5'h00;
   logic [7:0] port_a_in = 8'hff;
   logic [7:0] addr, wdata, rdata_out, core_mode_control_out, core_flags_out, e_q, rnd;
   logic       wr, rd, halt, wdclr, rd_seen = 1'b0;
   logic       use_fast_clock_out, fast_osc_enable_out, slow_osc_enable_out;
   logic       core_run_out, timers_run_out, int_hold_out;
   int         num_errors = 0;
   int         checks_done = 0;
   int         wcnt = 0;
   int         seed = 32'h73ae;
   logic [7:0] expq[$];

   // system clock 125 MHz; fast oscillator slower, unrelated in phase, still while disabled
   always #4 clk_sys_in = ~clk_sys_in;
   always #21 fosc = (fast_osc_enable_out === 1'b1) ? ~fosc : 1'b0;

   core_model core (.clk_sys_in(clk_sys_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
      .rd_out(rd), .halt_out(halt), .wdclr_out(wdclr));

   operating_mode_wake_control #(.WARM_CYCLES(WARM), .OPTION_WAKE_EDGE(0)) i_operating_mode_wake_control (
      .clk_sys_in(clk_sys_in), .reset_in(reset_in), .por_event_in(ev[2]),
      .reset_pin_low_active_in(~ev[3]), .watchdog_timeout_in(ev[1]), .initial_mode_option_in(opt),
      .halt_instruction_in(halt), .watchdog_clear_instruction_in(wdclr), .port_a_in(port_a_in),
      .timer_one_underflow_in(ev[0]), .fast_oscillator_clock_in(fosc), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out),
      .use_fast_clock_out(use_fast_clock_out), .fast_osc_enable_out(fast_osc_enable_out),
      .slow_osc_enable_out(slow_osc_enable_out), .core_run_out(core_run_out),
      .timers_run_out(timers_run_out), .int_hold_out(int_hold_out),
      .core_mode_control_out(core_mode_control_out), .core_flags_out(core_flags_out));

   // read data stands only in the cycle after the strobe, so compare exactly there
   always @(posedge clk_sys_in) begin
      if (rd_seen) begin
         e_q = expq.pop_front();
         `CHK("rdata", e_q, rdata_out)
      end else if (!reset_in) begin
         `CHK("rdata_idle", 8'h00, rdata_out)
      end
      rd_seen <= rd;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      core.access(a, d, 1'b1);
   endtask

   // expectation is queued before the strobe leaves
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      core.access(a, 8'h00, 1'b0);
   endtask

   // event k held for n cycles: 0 underflow, 1 watchdog timeout, 2 power-on, 3 reset pin
   task automatic pulse(input int k, input int n);
      @(posedge clk_sys_in);
      ev <= 5'h01 << k;
      repeat (n) @(posedge clk_sys_in);
      ev <= 5'h00;
      tick(1);
   endtask

   task automatic set_pa(input logic [7:0] v);
      @(posedge clk_sys_in);
      port_a_in <= v;
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      num_errors++;
      $display("ERROR run_length expected end seen none");
      test_done();
   end

   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      tick(2);
      `CHK("flags_top", 2'b11, core_flags_out[7:6])
      rreg(`OFS_CORE_MODE_CONTROL, 8'h00);
      rreg(`OFS_TIMER_ONE_CONTROL, 8'h00);
      rreg(`OFS_PORT_A_WAKE, 8'h00);
      rreg(8'h40, 8'h00);
      wreg(`OFS_CORE_MODE_CONTROL, 8'h7c);
      rreg(`OFS_CORE_MODE_CONTROL, 8'h04);
      wreg(`OFS_TIMER_ONE_CONTROL, 8'hff);
      rreg(`OFS_TIMER_ONE_CONTROL, 8'h9b);
      rnd = $random(seed);
      wreg(`OFS_CORE_FLAGS, rnd);
      rreg(`OFS_CORE_FLAGS, {2'b11, rnd[5:0]});
      $display("test registers done");
      // slow to fast changeover waits for the oscillator delay
      wreg(`OFS_CORE_MODE_CONTROL, 8'h01);
      tick(1);
      `CHK("fast_osc_on", 1'b1, fast_osc_enable_out)
      tick(12300);
      `CHK("use_fast_early", 1'b0, use_fast_clock_out)
      `WAITC(use_fast_clock_out === 1'b1, 700)
      `CHK("use_fast", 1'b1, use_fast_clock_out)
      $display("test fast switch done");
      // light standby: timer wake disabled first, then pin wake, then timer wake
      wreg(`OFS_PORT_A_WAKE, 8'h01);
      wreg(`OFS_TIMER_ONE_CONTROL, 8'h1b);
      wreg(`OFS_CORE_MODE_CONTROL, 8'h03);
      core.instr(1'b0);
      tick(2);
      `CHK("standby_osc", 3'b001, {core_run_out, fast_osc_enable_out, slow_osc_enable_out})
      `CHK("standby_hold", 2'b01, {timers_run_out, int_hold_out})
      pulse(0, 1);
      tick(4);
      `CHK("t1_off", 1'b0, core_run_out)
      set_pa(8'hfe);
      `WAITC(core_run_out === 1'b1, 20)
      set_pa(8'hff);
      wreg(`OFS_TIMER_ONE_CONTROL, 8'h9b);
      core.instr(1'b0);
      tick(2);
      `CHK("standby_again", 1'b0, core_run_out)
      pulse(0, 1);
      `WAITC(core_run_out === 1'b1 && use_fast_clock_out === 1'b1, 13000)
      `CHK("resume_run", 2'b10, {timers_run_out, int_hold_out})
      $display("test standby done");
      // deep halt: one enable bit at a time, a disabled pin and the timer must not wake it
      wreg(`OFS_CORE_MODE_CONTROL, 8'h00);
      for (int b = 0; b < 8; b++) begin
         wreg(`OFS_PORT_A_WAKE, 8'h01 << b);
         core.instr(1'b0);
         tick(2);
         `CHK("halt_osc", 3'b000, {core_run_out, fast_osc_enable_out, slow_osc_enable_out})
         `CHK("halt_flags", 2'b10, core_flags_out[7:6])
         rnd = $random(seed);
         wreg(`OFS_PORT_A_WAKE, rnd);
         pulse(0, 1);
         set_pa(~(8'h01 << ((b + 1) % 8)));
         tick(6);
         `CHK("halt_masked", 1'b0, core_run_out)
         set_pa(~(8'h01 << b));
         tick(4);
         `CHK("warm_hold", 1'b0, core_run_out)
         `WAITC(core_run_out === 1'b1, WARM + 20)
         set_pa(8'hff);
         rreg(`OFS_PORT_A_WAKE, 8'h01 << b);
      end
      $display("test deep halt done");
      // status flags and initial mode across the reset sources
      core.instr(1'b1);
      tick(2);
      `CHK("wdclr_flags", 2'b11, core_flags_out[7:6])
      @(posedge clk_sys_in);
      opt <= 1'b1;
      pulse(1, 1);
      tick(3);
      `CHK("wdt_flags", 2'b01, core_flags_out[7:6])
      `CHK("wdt_mode", 1'b1, core_mode_control_out[0])
      rreg(`OFS_TIMER_ONE_CONTROL, 8'h00);
      @(posedge clk_sys_in);
      opt <= 1'b0;
      pulse(2, 1);
      tick(3);
      `CHK("por_flags", 2'b11, core_flags_out[7:6])
      `CHK("por_mode", 1'b0, core_mode_control_out[0])
      pulse(1, 1);
      tick(3);
      `CHK("wdt_flags2", 2'b01, core_flags_out[7:6])
      pulse(3, 4);
      tick(4);
      `CHK("pin_flags", 2'b11, core_flags_out[7:6])
      $display("test reset sources done");
      tick(4);
      test_done();
   end
endmodule
